// ### adc_port_pkg.sv
/*
 * Constants for the two-wire result and configuration port of a 16-bit
 * converter: framing, addresses, program word layout and timing counts.
 * Assumes a 250 MHz core clock; the bus pins are sampled, not clocked.
 */
package adc_port_pkg;

	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned CONV_SLOW_US    = 4800;
	localparam int unsigned CONV_FAST_US    = 1200;
	localparam int unsigned CONV_SLOW_CYC   = CLK_HZ / 1_000_000 * CONV_SLOW_US;
	localparam int unsigned CONV_FAST_CYC   = CLK_HZ / 1_000_000 * CONV_FAST_US;
	localparam int unsigned CONV_CNT_W      = 21;

	localparam logic [5:0]  ADDR_LOW_BITS   = 6'h14;
	localparam int unsigned ADDR_SEL_POS    = 6;
	localparam logic        DIR_READ        = 1'b1;

	localparam int unsigned RESULT_W        = 16;
	localparam int unsigned BYTE_BITS       = 8;
	localparam int unsigned PROG_BITS       = 4;
	localparam int unsigned KEY_HIGH_POS    = 3;
	localparam int unsigned KEY_LOW_POS     = 2;
	localparam int unsigned RATE_POS        = 1;
	localparam int unsigned DEEP_PD_POS     = 0;
	localparam logic        RATE_RESET      = 1'b0;
	localparam logic        DEEP_PD_RESET   = 1'b0;

	localparam logic [15:0] CODE_MAX        = 16'hffff;
	localparam logic [15:0] CODE_MID        = 16'h8000;

	// Bus sequencer states.
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_ADDR = 3'b001,
		BUS_AACK = 3'b010,
		BUS_READ = 3'b011,
		BUS_RACK = 3'b100,
		BUS_PROG = 3'b101,
		BUS_SKIP = 3'b110
	} bus_state_t;

	// Converter states.
	typedef enum logic [1:0] {
		CNV_RUN  = 2'b00,
		CNV_NAP  = 2'b01,
		CNV_HOLD = 2'b10
	} cnv_state_t;

endpackage : adc_port_pkg

// ### adc_i2c_port.sv
/*
 * Target side of the two-wire result and configuration port.
 * Assumes scl and sda arrive asynchronously and are synchronised here;
 * the analog side supplies a sample that is latched when a conversion
 * ends. sda is open drain: the pin is pulled low while sda_oe is high.
 */
`timescale 1ns/100ps
`default_nettype none

module adc_i2c_port #(
	// Offset binary when set, straight binary otherwise.
	parameter bit          DIFFERENTIAL = 1'b1,
	// Conversion lengths in core clock cycles, slow and fast rate.
	parameter int unsigned SLOW_CYCLES  = adc_port_pkg::CONV_SLOW_CYC,
	parameter int unsigned FAST_CYCLES  = adc_port_pkg::CONV_FAST_CYC
) (
	input  wire logic        ref_clk,      // Core clock, 250 MHz.
	input  wire logic        rst_n,        // Asynchronous power-on reset.
	input  wire logic        scl_in,       // Bus clock pin level.
	input  wire logic        sda_in,       // Bus data pin level.
	output logic             sda_out,      // Driven level, always low.
	output logic             sda_oe,       // High while pulling sda low.
	input  wire logic        addr_select_pin, // Address select strap.
	input  wire logic signed [17:0] sample_in, // Raw analog estimate.
	output logic             converting,   // Conversion in progress.
	output logic             adc_powered,  // Converter supply on.
	output logic             ref_powered,  // Reference supply on.
	output logic             rate_select,  // Current rate setting.
	output logic             deep_power_down // Current sleep setting.
);
	import adc_port_pkg::*;

	typedef struct packed {
		logic [1:0]            scl_s;
		logic [1:0]            sda_s;
		logic                  scl_d;
		logic                  sda_d;
		bus_state_t            bst;
		logic [3:0]            bits;
		logic [7:0]            shf;
		logic [4:0]            rd_cnt;
		logic                  oe;
		logic                  ack_good;
		logic                  was_read;
		logic [PROG_BITS-1:0]  prog;
		logic                  rate;
		logic                  deep;
		logic                  deep_armed;
		cnv_state_t            cst;
		logic [CONV_CNT_W-1:0] cnt;
		logic [15:0]           result;
		logic                  refon;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// Refuse lengths that the down counter cannot hold or that are empty.
	if (SLOW_CYCLES >= (1 << CONV_CNT_W) || FAST_CYCLES >= (1 << CONV_CNT_W)
		|| SLOW_CYCLES == 0 || FAST_CYCLES == 0) begin : g_bad_len
		$error("Conversion length does not fit the counter.");
	end

	// Clamp the raw sample into the output code space.
	function automatic logic [15:0] encode(input logic signed [17:0] v);
		logic signed [17:0] off;
		off = DIFFERENTIAL ? 18'(v + 18'sh0_8000) : v;
		if (off < 18'sh0_0000)
			encode = 16'h0000;
		else if (off > 18'sh0_ffff)
			encode = CODE_MAX;
		else
			encode = off[15:0];
	endfunction

	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [6:0] my_addr;
	logic start_conv;

	assign scl_rise = s_r.scl_s[1] & ~s_r.scl_d;
	assign scl_fall = ~s_r.scl_s[1] & s_r.scl_d;
	// Start and stop are data edges while the clock stays high.
	assign start_c  = s_r.scl_s[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_s[1];
	assign stop_c   = s_r.scl_s[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_s[1];
	assign my_addr  = {addr_select_pin, ADDR_LOW_BITS};

	// Next state: bus sequencer, then converter.
	always_comb begin
		s_nxt = s_r;
		start_conv = 1'b0;
		s_nxt.scl_s = {s_r.scl_s[0], scl_in};
		s_nxt.sda_s = {s_r.sda_s[0], sda_in};
		s_nxt.scl_d = s_r.scl_s[1];
		s_nxt.sda_d = s_r.sda_s[1];

		case (s_r.bst)
			BUS_IDLE, BUS_SKIP: begin
				s_nxt.oe = 1'b0;
			end
			BUS_ADDR: begin
				if (scl_rise) begin
					s_nxt.shf  = {s_r.shf[6:0], s_r.sda_s[1]};
					s_nxt.bits = s_r.bits + 4'h1;
				end
				if (scl_fall && s_r.bits == 4'(BYTE_BITS)) begin
					s_nxt.bits = 4'h0;
					s_nxt.was_read = (s_r.shf[0] == DIR_READ);
					if (s_r.shf[7:1] == my_addr) begin
						s_nxt.bst = BUS_AACK;
						// Busy converter leaves the line released.
						s_nxt.ack_good = (s_r.cst != CNV_RUN);
						s_nxt.oe = (s_r.cst != CNV_RUN);
					end else begin
						s_nxt.bst = BUS_SKIP;
					end
				end
			end
			BUS_AACK: begin
				if (scl_fall) begin
					if (!s_r.ack_good) begin
						s_nxt.bst = BUS_SKIP;
						s_nxt.oe  = 1'b0;
					end else if (s_r.was_read) begin
						s_nxt.bst    = BUS_READ;
						s_nxt.rd_cnt = 5'd0;
						s_nxt.oe     = ~s_r.result[15];
					end else begin
						s_nxt.bst = BUS_PROG;
						s_nxt.oe  = 1'b0;
					end
				end
			end
			BUS_READ: begin
				// Release for the controller's acknowledge bit.
				if (scl_rise)
					s_nxt.bits = s_r.bits + 4'h1;
				if (scl_fall) begin
					s_nxt.rd_cnt = s_r.rd_cnt + 5'd1;
					if (s_r.bits == 4'(BYTE_BITS)) begin
						s_nxt.bits = 4'h0;
						s_nxt.oe   = 1'b0;
						s_nxt.bst  = BUS_RACK;
					end else
						s_nxt.oe = ~s_r.result[4'(15 - s_r.rd_cnt[3:0] - 4'h1)];
					if (s_r.rd_cnt == 5'(RESULT_W - 1)) begin
						s_nxt.oe = 1'b0;
					end
				end
			end
			BUS_RACK: begin
				if (scl_fall) begin
					if (s_r.rd_cnt >= 5'(RESULT_W)) begin
						s_nxt.bst  = BUS_SKIP;
						start_conv = 1'b1;
					end else begin
						s_nxt.bst = BUS_READ;
						s_nxt.oe  = ~s_r.result[4'(15 - s_r.rd_cnt[3:0])];
					end
				end
			end
			BUS_PROG: begin
				if (scl_rise && s_r.bits < 4'(PROG_BITS)) begin
					s_nxt.prog = {s_r.prog[2:0], s_r.sda_s[1]};
					s_nxt.bits = s_r.bits + 4'h1;
				end
			end
			default: s_nxt.bst = BUS_IDLE;
		endcase

		// Program word takes effect when the write ends.
		if (s_r.bst == BUS_PROG && (stop_c || start_c)) begin
			if (s_r.bits == 4'(PROG_BITS) && s_r.prog[KEY_HIGH_POS]
				&& !s_r.prog[KEY_LOW_POS]) begin
				s_nxt.rate = s_r.prog[RATE_POS];
				s_nxt.deep = s_r.prog[DEEP_PD_POS];
			end
			start_conv = 1'b1;
		end
		// Stop inside a read ends the transfer and restarts conversion.
		if ((s_r.bst == BUS_READ || s_r.bst == BUS_RACK) && stop_c)
			start_conv = 1'b1;
		if (s_r.bst == BUS_AACK && stop_c && s_r.ack_good)
			start_conv = 1'b1;

		if (start_c) begin
			s_nxt.bst  = BUS_ADDR;
			s_nxt.bits = 4'h0;
			s_nxt.oe   = 1'b0;
		end else if (stop_c) begin
			s_nxt.bst = BUS_IDLE;
			s_nxt.oe  = 1'b0;
		end

		// Converter: a running conversion is cut short only by reset.
		case (s_r.cst)
			CNV_RUN: begin
				if (s_r.cnt == '0) begin
					s_nxt.result = encode(sample_in);
					s_nxt.cst    = CNV_NAP;
					if (s_r.deep_armed)
						s_nxt.refon = 1'b0;
				end else
					s_nxt.cnt = s_r.cnt - 1'b1;
			end
			CNV_NAP: begin
				// A valid acknowledge wakes the reference.
				if (s_r.bst == BUS_ADDR && s_nxt.bst == BUS_AACK
					&& s_nxt.ack_good) begin
					s_nxt.refon = 1'b1;
					s_nxt.cst   = CNV_HOLD;
				end
			end
			CNV_HOLD: begin
				if (start_conv) begin
					s_nxt.cst = CNV_RUN;
					s_nxt.deep_armed = s_nxt.deep;
					s_nxt.cnt = s_nxt.rate
						? CONV_CNT_W'(FAST_CYCLES - 1)
						: CONV_CNT_W'(SLOW_CYCLES - 1);
				end else if (s_r.bst == BUS_SKIP || s_r.bst == BUS_IDLE)
					s_nxt.cst = CNV_NAP;
			end
			default: s_nxt.cst = CNV_RUN;
		endcase
	end

	// Single state register; reset clears settings and starts converting.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r            <= '0;
			s_r.scl_s      <= 2'b11;
			s_r.sda_s      <= 2'b11;
			s_r.scl_d      <= 1'b1;
			s_r.sda_d      <= 1'b1;
			s_r.bst        <= BUS_IDLE;
			s_r.rate       <= RATE_RESET;
			s_r.deep       <= DEEP_PD_RESET;
			s_r.cst        <= CNV_RUN;
			s_r.cnt        <= CONV_CNT_W'(SLOW_CYCLES - 1);
			s_r.result     <= CODE_MID;
			s_r.refon      <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs come straight from the state register; sda_out is tied low.
	assign sda_out         = 1'b0;
	assign sda_oe          = s_r.oe;
	assign converting      = (s_r.cst == CNV_RUN);
	assign adc_powered     = (s_r.cst == CNV_RUN);
	assign ref_powered     = s_r.refon;
	assign rate_select     = s_r.rate;
	assign deep_power_down = s_r.deep;

endmodule // adc_i2c_port

`default_nettype wire

// ### adc_i2c_port_monitor.sv
/* Checker for the two-wire converter port, bound to its ports.
   Takes the conversion lengths from the bound instance. */
`timescale 1ns/100ps
`default_nettype none
module adc_i2c_port_monitor
	import adc_port_pkg::*;
#(
	parameter int unsigned SLOW_CYCLES = CONV_SLOW_CYC, // Slow length.
	parameter int unsigned FAST_CYCLES = CONV_FAST_CYC  // Fast length.
) (
	input wire logic ref_clk,        // Core clock.
	input wire logic rst_n,          // Async reset.
	input wire logic scl_in,         // Bus clock level.
	input wire logic sda_out,        // Driven data level.
	input wire logic sda_oe,         // Data pull enable.
	input wire logic converting,     // Conversion running.
	input wire logic adc_powered,    // Converter supply.
	input wire logic ref_powered,    // Reference supply.
	input wire logic rate_select,    // Rate setting.
	input wire logic deep_power_down // Sleep setting.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [20:0] run_r;
	// Length of the running conversion, so a cut-short one is seen.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			run_r <= 21'h0_0000;
		else
			run_r <= converting ? run_r + 21'h0_0001 : 21'h0_0000;
	end
	a_out_low: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda changed while scl high");
	a_no_ack_busy: assert property (
		converting && $past(converting) |-> !sda_oe)
		else $error("line pulled during conversion");
	a_adc_on: assert property (converting |-> adc_powered)
		else $error("converter off while converting");
	a_ref_with_adc: assert property (adc_powered |-> ref_powered)
		else $error("reference off under converter");
	a_ref_sleep: assert property (!ref_powered |-> deep_power_down)
		else $error("reference off in nap mode");
	a_set_hold: assert property ($past(converting) && converting
		|-> $stable(rate_select) && $stable(deep_power_down))
		else $error("settings moved in conversion");
	a_conv_len: assert property ($fell(converting) |->
		(rate_select ? run_r + 4 >= FAST_CYCLES && run_r <= FAST_CYCLES + 4
		: run_r + 4 >= SLOW_CYCLES && run_r <= SLOW_CYCLES + 4))
		else $error("conversion length wrong");
	a_reset_dflt: assert property ($rose(rst_n) |->
		converting && !rate_select && !deep_power_down)
		else $error("reset state wrong");
	c_ack: cover property ($rose(sda_oe));
	c_conv_end: cover property ($fell(converting));
	c_bus: cover property ($fell(scl_in));
endmodule // adc_i2c_port_monitor
bind adc_i2c_port adc_i2c_port_monitor #(.SLOW_CYCLES(SLOW_CYCLES),
	.FAST_CYCLES(FAST_CYCLES)) adc_i2c_port_monitor_inst (
	.ref_clk, .rst_n, .scl_in, .sda_out, .sda_oe, .converting,
	.adc_powered, .ref_powered, .rate_select, .deep_power_down);
`default_nettype wire

// ### bus_ctl_model.sv
/* Bus controller model driving the clock and pulling the data line.
   Assumes the bench resolves the open-drain line with a pull-up. */
`timescale 1ns/100ps
`default_nettype none
module bus_ctl_model (
	input  wire logic ref_clk,  // Core clock paces the bus.
	input  wire logic sda_line, // Resolved data line.
	output logic      scl_drv,  // Bus clock, high when idle.
	output logic      sda_low   // High while pulling data low.
);
	localparam int QTR = 10; // Quarter of a 160 ns bus period.
	initial begin
		scl_drv = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Data moves only while the clock is low.
	task automatic put_bit(input logic b, output logic seen);
		scl_drv <= 1'b0;
		tick(QTR);
		sda_low <= ~b;
		tick(QTR);
		scl_drv <= 1'b1;
		tick(QTR);
		seen = sda_line;
		tick(QTR);
	endtask
	task automatic start_cond;
		sda_low <= 1'b1;
		tick(2 * QTR);
	endtask
	task automatic stop_cond;
		scl_drv <= 1'b0;
		tick(QTR);
		sda_low <= 1'b1;
		tick(QTR);
		scl_drv <= 1'b1;
		tick(QTR);
		sda_low <= 1'b0;
		tick(2 * QTR);
	endtask
	// Eight bits then a released ninth bit; program words have four.
	task automatic send_bits(input logic [7:0] v, input int n,
		output logic ack);
		logic s;
		for (int i = n - 1; i >= 0; i--)
			put_bit(v[i], s);
		ack = 1'b1;
		if (n == 8)
			put_bit(1'b1, ack);
	endtask
endmodule // bus_ctl_model
`default_nettype wire

// ### adc_i2c_port_tb_top.sv
/* Bench for the converter port: refused traffic during conversion,
   then a program write, sleep and wake, a full read and a mid-run reset.
   Assumes shortened conversion lengths set at the instance. */
`timescale 1ns/100ps
`default_nettype none
module adc_i2c_port_tb_top;
	import adc_port_pkg::*;
	logic ref_clk = 1'b0, rst_n, sel, scl_drv, sda_low, sda_out, sda_oe;
	logic converting, adc_powered, ref_powered, rate_sel, deep_pd, ack;
	logic signed [17:0] sample_in;
	logic [7:0] adr;
	logic b;
	logic [15:0] exp_res = 16'h9234; // Sample plus midscale offset.
	wire logic sda_line;
	int err_count = 0, checks_done = 0, cyc = 0;
	// Open drain with pull-up: low if either side pulls.
	assign sda_line = ~sda_low & (sda_oe ? sda_out : 1'b1);
	always #2 ref_clk = ~ref_clk;
	// Short conversions keep the run small; the first outlasts the refusals.
	adc_i2c_port #(.SLOW_CYCLES(8000), .FAST_CYCLES(2000))
		adc_i2c_port_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.scl_in(scl_drv), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_select_pin(sel), .sample_in(sample_in),
		.converting(converting), .adc_powered(adc_powered),
		.ref_powered(ref_powered), .rate_select(rate_sel),
		.deep_power_down(deep_pd));
	bus_ctl_model bus_ctl_model_inst (.ref_clk(ref_clk),
		.sda_line(sda_line), .scl_drv(scl_drv), .sda_low(sda_low));
	task automatic check(input string what, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			$display("[ERR] %s expected %b seen %b", what, e, g);
			err_count++;
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Wait until the running conversion has ended.
	task automatic wait_done;
		while (converting)
			@(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
	endtask
	// A hang is cut short well past the expected run of some 11800 cycles.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		rst_n = 1'b0;
		sel = 1'b0;
		sample_in = 18'sh0_1234;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		check("converting", 1'b1, converting);
		check("ref_powered", 1'b1, ref_powered);
		check("rate_select", 1'b0, rate_sel);
		check("deep_power_down", 1'b0, deep_pd);
		// Own and foreign address, both directions, both strap levels.
		for (int s = 0; s < 2; s++) begin
			@(posedge ref_clk);
			sel <= s[0];
			for (int k = 0; k < 4; k++) begin
				adr = {s[0] ^ k[1], ADDR_LOW_BITS, k[0]};
				bus_ctl_model_inst.start_cond();
				bus_ctl_model_inst.send_bits(adr, 8, ack);
				check("address ack", 1'b1, ack);
				if (!k[0])
					bus_ctl_model_inst.send_bits(8'h0b, 4, ack);
				bus_ctl_model_inst.stop_cond();
			end
		end
		#1;
		check("rate_select kept", 1'b0, rate_sel);
		check("deep_power_down kept", 1'b0, deep_pd);
		check("still converting", 1'b1, converting);
		check("reference on", 1'b1, ref_powered);
		// Program fast rate and deep power-down, strap is high now.
		wait_done();
		bus_ctl_model_inst.start_cond();
		bus_ctl_model_inst.send_bits(8'ha8, 8, ack);
		check("write ack", 1'b0, ack);
		bus_ctl_model_inst.send_bits(8'h0b, 4, ack);
		bus_ctl_model_inst.stop_cond();
		check("rate_select set", 1'b1, rate_sel);
		check("deep_power_down set", 1'b1, deep_pd);
		check("write restarts", 1'b1, converting);
		wait_done();
		check("reference asleep", 1'b0, ref_powered);
		check("converter off", 1'b0, adc_powered);
		bus_ctl_model_inst.start_cond();
		bus_ctl_model_inst.send_bits(8'ha9, 8, ack);
		check("read ack", 1'b0, ack);
		check("reference woken", 1'b1, ref_powered);
		// Result latched before sleep; the next one is discarded.
		for (int i = 15; i >= 0; i--) begin
			bus_ctl_model_inst.put_bit(1'b1, b);
			check($sformatf("result bit %0d", i), exp_res[i], b);
			if (i == 8)
				bus_ctl_model_inst.put_bit(1'b0, b);
		end
		bus_ctl_model_inst.put_bit(1'b1, b);
		bus_ctl_model_inst.stop_cond();
		check("read restarts", 1'b1, converting);
		// Reset in mid-run clears the settings again.
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		check("rate_select reset", 1'b0, rate_sel);
		check("deep_power_down reset", 1'b0, deep_pd);
		check("converting reset", 1'b1, converting);
		check("reference reset", 1'b1, ref_powered);
		print_verdict();
	end
endmodule // adc_i2c_port_tb_top
`default_nettype wire
